// [hw/acp_params.svh]
/*
 Constants of the converter control and output port: times, counts, bit positions.
 Assumes the includer compiles it once per unit; guarded anyway.
*/
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH
`define ACP_CLK_NS     100
`define ACP_CONV_NS    1000
`define ACP_CONV_CYC   ((`ACP_CONV_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_ACQ_NS     500
`define ACP_ACQ_CYC    ((`ACP_ACQ_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
`define ACP_SCLK_HALF  2
`define ACP_WORD_BITS  16
`define ACP_BIT_SDO    8
`define ACP_BIT_SCLK   9
`define ACP_BIT_SYNC   10
`define ACP_BIT_ERR    11
`define ACP_CNT_RST    8'h00
`define ACP_WORD_RST   16'h0000
`endif

// [hw/acp_pkg.sv]
/*
 Types of the converter control and output port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package acp_pkg;
	// Conversion sequencer states
	typedef enum logic [1:0] {
		ACP_IDLE  = 2'b00,
		ACP_CONV  = 2'b01,
		ACP_LATCH = 2'b10,
		ACP_ACQ   = 2'b11
	} acp_state_t;
	// Synchronised pin levels, carried together
	typedef struct packed {
		logic ser;      // Serial port selected
		logic ext;      // External serial clock
		logic sclk_inv; // Serial clock invert
		logic sync_inv; // Frame sync invert
		logic rdc;      // Read during conversion
		logic impulse;  // Low-power mode
		logic warp;     // Fast-rate mode
		logic pd;       // Power-down request
		logic reset;    // Reset pin
		logic cs_n;     // Chip select
		logic rd_n;     // Read strobe
		logic cnv_n;    // Convert start
	} acp_pins_t;
endpackage : acp_pkg

// [hw/acp_top.sv]
/*
 Converter control and output port: conversion sequencing, busy, parallel
 and serial (master or slave) result port.
 Assumes the analog core presents SAMPLE_CODE stably on CLK_SYS and that the
 host keeps the mode pins quasi-static around reads.
*/
// Overview of operation
// - Serial mode puts clock, sync, error on bits 9-11
// - Serial clock pin out internally, in externally
// - Clock invert picks the data update edge
// - Sync high during master read when invert low
// - Sync low during master read when invert high
// - Slave read overrun replaces word, pulses error
// - Bits 12 to 15 are outputs in serial mode too
// - Busy high from start until result latched
// - Output bus enabled only with select and read
// - Chip select gates the external serial clock
// - Reset pin aborts any conversion
// - Power-down finishes conversion, then blocks starts
// - Convert start falling edge holds and converts
// - Low-power mode starts if start held low, fast-rate off
// - Internal clock data valid on both edges
// - External clock updates on selected edge
// - Result shifted out most significant first
// - Read mode picks master read during or after conversion
`timescale 1ns/1ps
`include "acp_params.svh"
module acp_top #(
	parameter int unsigned CONV_CYC  = `ACP_CONV_CYC,
	parameter int unsigned ACQ_CYC   = `ACP_ACQ_CYC,
	parameter int unsigned SCLK_HALF = `ACP_SCLK_HALF
) (
	input  wire logic        CLK_SYS,                // System clock
	input  wire logic        RSTN,                   // Async reset, low
	input  wire logic        SCLK_EXT,               // External serial clock
	input  wire logic        SERIAL_PARALLEL_SELECT, // High: serial port
	input  wire logic        CLOCK_SOURCE_SELECT,    // High: external clock
	input  wire logic        SERIAL_CLOCK_INVERT,    // Clock edge select
	input  wire logic        FRAME_SYNC_INVERT,      // Sync polarity
	input  wire logic        READ_MODE_OR_CHAIN_IN,  // Read during conversion
	input  wire logic        LOW_POWER_MODE,         // Reduced power mode
	input  wire logic        FAST_RATE_MODE,         // Fast-rate mode
	input  wire logic        POWER_DOWN_REQUEST,     // Power-down pin
	input  wire logic        RESET_IN,               // Reset pin, high
	input  wire logic        CS_N,                   // Chip select
	input  wire logic        RD_N,                   // Read strobe
	input  wire logic        CONVERT_START_N,        // Convert start
	input  wire logic [15:0] SAMPLE_CODE,            // Core result
	output logic      [15:0] DATA_OUT,               // Data pin levels
	output logic      [15:0] DATA_OE_N,              // Pin drive, low
	output logic             BUSY,                   // Conversion busy
	output logic             HOLD,                   // Sample/hold in hold
	output logic             POWER_REDUCED           // Reduced power state
);
	// Pin synchroniser, two stages
	acp_pkg::acp_pins_t pin_m_q;   // First stage, read by pin_q only
	acp_pkg::acp_pins_t pin_q;     // Usable pin levels
	acp_pkg::acp_pins_t pin_raw;   // Raw pins
	assign pin_raw = {SERIAL_PARALLEL_SELECT, CLOCK_SOURCE_SELECT,
		SERIAL_CLOCK_INVERT, FRAME_SYNC_INVERT, READ_MODE_OR_CHAIN_IN,
		LOW_POWER_MODE, FAST_RATE_MODE, POWER_DOWN_REQUEST, RESET_IN,
		CS_N, RD_N, CONVERT_START_N};
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			pin_m_q <= 12'h007;
			pin_q   <= 12'h007;
		end else begin
			pin_m_q <= pin_raw;
			pin_q   <= pin_m_q;
		end
	end

	// Sequencer state
	acp_pkg::acp_state_t st_q, st_d; // Conversion state
	logic [7:0]  cnt_q, cnt_d;       // Phase counter
	logic        cnv_prev_q;         // Start pin, one cycle late
	logic        push;               // Result into buffer
	logic        cnv_fall;           // Start falling edge
	logic        buf_full;           // Buffer cannot take
	assign cnv_fall = cnv_prev_q && !pin_q.cnv_n;
	// Next state of the sequencer
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		push  = 1'b0;
		if (pin_q.reset) begin
			st_d  = acp_pkg::ACP_IDLE;
			cnt_d = `ACP_CNT_RST;
		end else begin
			case (st_q)
				acp_pkg::ACP_IDLE: begin
					// Power-down only blocks new starts
					if (cnv_fall && !pin_q.pd) begin
						st_d  = acp_pkg::ACP_CONV;
						cnt_d = `ACP_CNT_RST;
					end
				end
				acp_pkg::ACP_CONV: begin
					if (cnt_q == 8'(CONV_CYC - 1)) begin
						st_d = acp_pkg::ACP_LATCH;
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
				end
				acp_pkg::ACP_LATCH: begin
					// A full buffer stalls here with busy still high
					if (!buf_full) begin
						push  = 1'b1;
						st_d  = acp_pkg::ACP_ACQ;
						cnt_d = `ACP_CNT_RST;
					end
				end
				acp_pkg::ACP_ACQ: begin
					if (cnt_q == 8'(ACQ_CYC - 1)) begin
						st_d = acp_pkg::ACP_IDLE;
						// Held-low start converts at once
						if (pin_q.impulse && !pin_q.warp && !pin_q.cnv_n
							&& !pin_q.pd) begin
							st_d  = acp_pkg::ACP_CONV;
							cnt_d = `ACP_CNT_RST;
						end
					end else begin
						cnt_d = cnt_q + 8'h01;
					end
				end
				default: st_d = acp_pkg::ACP_IDLE;
			endcase
		end
	end
	// Sequencer registers and status outputs
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			st_q          <= acp_pkg::ACP_IDLE;
			cnt_q         <= `ACP_CNT_RST;
			cnv_prev_q    <= 1'b1;
			BUSY          <= 1'b0;
			HOLD          <= 1'b0;
			POWER_REDUCED <= 1'b0;
		end else begin
			st_q          <= st_d;
			cnt_q         <= cnt_d;
			cnv_prev_q    <= pin_q.cnv_n;
			BUSY          <= st_d == acp_pkg::ACP_CONV
				|| st_d == acp_pkg::ACP_LATCH;
			HOLD          <= st_d == acp_pkg::ACP_CONV;
			POWER_REDUCED <= pin_q.pd && st_d == acp_pkg::ACP_IDLE;
		end
	end

	// Two-entry result buffer; drained by the output word
	logic [15:0] buf_mem_q [2];       // Entries
	logic [15:0] buf_mem_d [2];       // Next entries
	logic        wp_q, wp_d, rp_q, rp_d; // Pointers
	logic [1:0]  fill_q, fill_d;      // Entries held
	logic        pop;                 // Word leaves buffer
	logic        m_act_q;             // Master read running
	assign buf_full = fill_q == 2'h2;
	assign pop = fill_q != 2'h0 && !m_act_q; // Master read stalls drain
	// Buffer next state
	always_comb begin
		buf_mem_d = buf_mem_q;
		wp_d      = wp_q;
		rp_d      = rp_q;
		fill_d    = fill_q;
		if (push) begin
			buf_mem_d[wp_q] = SAMPLE_CODE;
			wp_d            = !wp_q;
		end
		if (pop) begin
			rp_d = !rp_q;
		end
		fill_d = fill_q + {1'b0, push} - {1'b0, pop};
		if (pin_q.reset) begin
			wp_d   = 1'b0;
			rp_d   = 1'b0;
			fill_d = 2'h0;
		end
	end
	// Buffer registers
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			buf_mem_q[0] <= `ACP_WORD_RST;
			buf_mem_q[1] <= `ACP_WORD_RST;
			wp_q         <= 1'b0;
			rp_q         <= 1'b0;
			fill_q       <= 2'h0;
		end else begin
			buf_mem_q <= buf_mem_d;
			wp_q      <= wp_d;
			rp_q      <= rp_d;
			fill_q    <= fill_d;
		end
	end

	// Output word, master shifter and pin drive
	logic [15:0] word_q, word_d;   // Latest result
	logic        tgl_q, tgl_d;     // Flips per new word
	logic        new_q, new_d;     // Word not yet read out
	logic        err_d;            // Overrun this cycle
	logic        m_act_d;          // Master read next
	logic [15:0] m_sh_q, m_sh_d;   // Master shifter
	logic [4:0]  m_bit_q, m_bit_d; // Bits sent
	logic [7:0]  m_div_q, m_div_d; // Half-period divider
	logic        m_sclk_q, m_sclk_d; // Generated clock
	logic [15:0] dout_q, dout_d;   // Pin levels
	logic [15:0] oe_q, oe_d;       // Pin enables, low
	logic [1:0]  st_sy_q, dn_sy_q; // Link toggles, two-stage syncs
	logic        in_prog;          // Slave read open
	logic        en;               // Output bus enabled
	logic        lk_start_q, lk_done_q; // Link toggles
	assign in_prog = st_sy_q[0] != dn_sy_q[0];
	assign en      = !pin_q.cs_n && !pin_q.rd_n;
	// Next word, shifter and pin values
	always_comb begin
		word_d   = word_q;
		tgl_d    = tgl_q;
		new_d    = new_q;
		err_d    = 1'b0;
		m_act_d  = m_act_q;
		m_sh_d   = m_sh_q;
		m_bit_d  = m_bit_q;
		m_div_d  = m_div_q;
		m_sclk_d = m_sclk_q;
		if (pop) begin
			word_d = buf_mem_q[rp_q];
			tgl_d  = !tgl_q;
			new_d  = 1'b1;
			// Word replaced under an open slave read
			err_d  = pin_q.ser && pin_q.ext && in_prog;
		end
		if (!m_act_q) begin
			m_sclk_d = pin_q.sclk_inv;
			// Start after conversion unless read mode allows during
			if (pin_q.ser && !pin_q.ext && en && new_q
				&& (pin_q.rdc || !BUSY)) begin
				m_act_d = 1'b1;
				m_sh_d  = word_q;
				m_bit_d = 5'h00;
				m_div_d = `ACP_CNT_RST;
				new_d   = 1'b0;
			end
		end else if (m_div_q == 8'(SCLK_HALF - 1)) begin
			m_div_d  = `ACP_CNT_RST;
			m_sclk_d = !m_sclk_q;
			// Update on the selected edge only, so data spans both
			if (m_sclk_d != pin_q.sclk_inv) begin
				// First leading edge keeps the msb, later ones advance
				if (m_bit_q != 5'h00) begin
					m_sh_d = {m_sh_q[14:0], 1'b0};
				end
				m_bit_d = m_bit_q + 5'h01;
			end else begin
				// Trailing edge after the sixteenth leading one ends the read
				m_act_d = m_bit_q != 5'h10;
			end
		end else begin
			m_div_d = m_div_q + 8'h01;
		end
		if (pin_q.reset) begin
			m_act_d = 1'b0;
			new_d   = 1'b0;
			err_d   = 1'b0;
		end
		dout_d = word_q;
		oe_d   = 16'hFFFF;
		if (pin_q.ser) begin
			dout_d[`ACP_BIT_SDO]  = m_sh_q[15];
			// Clock pin leads the data by one cycle, so data settles around both edges
			dout_d[`ACP_BIT_SCLK] = m_sclk_d;
			dout_d[`ACP_BIT_SYNC] = m_act_q ^ pin_q.sync_inv;
			dout_d[`ACP_BIT_ERR]  = err_d;
		end
		if (en) begin
			oe_d = pin_q.ser ? 16'h00FF : 16'h0000;
			if (pin_q.ser && pin_q.ext) begin
				oe_d[`ACP_BIT_SCLK] = 1'b1; // Clock is an input
			end
		end
	end
	// Output registers and link toggle synchronisers
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			word_q   <= `ACP_WORD_RST;
			tgl_q    <= 1'b0;
			new_q    <= 1'b0;
			m_act_q  <= 1'b0;
			m_sh_q   <= `ACP_WORD_RST;
			m_bit_q  <= 5'h00;
			m_div_q  <= `ACP_CNT_RST;
			m_sclk_q <= 1'b0;
			dout_q   <= `ACP_WORD_RST;
			oe_q     <= 16'hFFFF;
			st_sy_q  <= 2'h0;
			dn_sy_q  <= 2'h0;
		end else begin
			word_q   <= word_d;
			tgl_q    <= tgl_d;
			new_q    <= new_d;
			m_act_q  <= m_act_d;
			m_sh_q   <= m_sh_d;
			m_bit_q  <= m_bit_d;
			m_div_q  <= m_div_d;
			m_sclk_q <= m_sclk_d;
			dout_q   <= dout_d;
			oe_q     <= oe_d;
			// Bit 1 is the first stage, bit 0 the usable one
			st_sy_q  <= {lk_start_q, st_sy_q[1]};
			dn_sy_q  <= {lk_done_q, dn_sy_q[1]};
		end
	end

	// Slave link: clock gated by chip select, edge chosen by invert
	// The clock runs only in frames, so the first two gated edges of a read
	// only carry the new-word toggle across; the host must clock them first
	logic        lclk;                // Link clock
	logic [1:0]  lk_tg_q, lk_rs_q;    // Toggle and reset syncs
	logic        lk_seen_q, lk_seen_d; // Last word taken
	logic        lk_act_q, lk_act_d;  // Read running
	logic [15:0] lk_sh_q, lk_sh_d;    // Slave shifter
	logic [3:0]  lk_cnt_q, lk_cnt_d;  // Edges in read
	logic        lk_start_d, lk_done_d; // Toggle next
	// Gating trades a clean clock tree for ignoring edges while deselected
	assign lclk = (SCLK_EXT ^ SERIAL_CLOCK_INVERT) & !CS_N;
	// Link next state; word_q is stable while its toggle crosses
	always_comb begin
		lk_seen_d  = lk_seen_q;
		lk_act_d   = lk_act_q;
		lk_sh_d    = lk_sh_q;
		lk_cnt_d   = lk_cnt_q;
		lk_start_d = lk_start_q;
		lk_done_d  = lk_done_q;
		if (lk_rs_q[0]) begin
			lk_act_d  = 1'b0;
			lk_done_d = lk_start_q;
		end else if (!lk_act_q && lk_tg_q[0] != lk_seen_q) begin
			lk_sh_d    = word_q;
			lk_seen_d  = lk_tg_q[0];
			lk_act_d   = 1'b1;
			lk_cnt_d   = 4'h0;
			lk_start_d = !lk_start_q;
		end else if (lk_act_q) begin
			if (lk_cnt_q == 4'hF) begin
				lk_act_d  = 1'b0;
				lk_done_d = !lk_done_q;
			end else begin
				lk_sh_d  = {lk_sh_q[14:0], 1'b0};
				lk_cnt_d = lk_cnt_q + 4'h1;
			end
		end
	end
	// Link registers
	always_ff @(posedge lclk or negedge RSTN) begin
		if (!RSTN) begin
			lk_tg_q    <= 2'h0;
			lk_rs_q    <= 2'h0;
			lk_seen_q  <= 1'b0;
			lk_act_q   <= 1'b0;
			lk_sh_q    <= `ACP_WORD_RST;
			lk_cnt_q   <= 4'h0;
			lk_start_q <= 1'b0;
			lk_done_q  <= 1'b0;
		end else begin
			lk_tg_q    <= {tgl_q, lk_tg_q[1]};
			lk_rs_q    <= {pin_q.reset, lk_rs_q[1]};
			lk_seen_q  <= lk_seen_d;
			lk_act_q   <= lk_act_d;
			lk_sh_q    <= lk_sh_d;
			lk_cnt_q   <= lk_cnt_d;
			lk_start_q <= lk_start_d;
			lk_done_q  <= lk_done_d;
		end
	end
	// Slave data bit comes from the link domain; a mux is unavoidable here
	assign DATA_OUT  = {dout_q[15:9], (pin_q.ser && pin_q.ext) ? lk_sh_q[15]
		: dout_q[8], dout_q[7:0]};
	assign DATA_OE_N = oe_q;

	// Checks on the system clock, and one on the link clock
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	sequence s_start;
		st_q == acp_pkg::ACP_IDLE && cnv_fall && !pin_q.pd && !pin_q.reset;
	endsequence
	sequence s_busy_run;
		BUSY [*8];
	endsequence
	start_busy_a: assert property (s_start |-> ##2 BUSY && HOLD)
		else $error("start edge did not raise busy");
	busy_hold_a: assert property (disable iff (!RSTN || pin_q.reset) s_start |-> ##2 s_busy_run)
		else $error("busy fell before conversion end");
	pd_block_a: assert property (st_q == acp_pkg::ACP_IDLE && pin_q.pd |=> st_q != acp_pkg::ACP_CONV)
		else $error("conversion started in power-down");
	reset_abort_a: assert property (pin_q.reset |-> ##2 !BUSY && st_q == acp_pkg::ACP_IDLE)
		else $error("reset did not abort conversion");
	oe_gate_a: assert property (!oe_q[15] |-> $past(en))
		else $error("bus driven without select and read");
	high_keep_a: assert property (en && pin_q.ser |=> oe_q[15:12] == 4'h0)
		else $error("upper bits not driven in serial mode");
	sync_pol_a: assert property ($rose(m_act_q) |=> dout_q[10] == !pin_q.sync_inv)
		else $error("frame sync level wrong in read");
	err_pulse_a: assert property (dout_q[11] && pin_q.ser |=> !dout_q[11])
		else $error("read error not a pulse");
	impulse_go_a: assert property (st_q == acp_pkg::ACP_ACQ && cnt_q == 8'(ACQ_CYC - 1)
		&& pin_q.impulse && !pin_q.warp && !pin_q.cnv_n && !pin_q.pd && !pin_q.reset
		|=> st_q == acp_pkg::ACP_CONV)
		else $error("held start did not convert");
	link_msb_a: assert property (@(posedge lclk) disable iff (!RSTN)
		$rose(lk_act_q) |-> lk_sh_q[15] == $past(word_q[15]))
		else $error("slave read did not start at msb");
endmodule : acp_top

// [testbench/acp_host_model.sv]
/*
 Host side of the serial slave link: makes the link clock only inside a
 frame and shifts in the data pin on each trailing clock edge.
 Assumes the bench raises go once per frame, with chip select and read low.
*/
`timescale 1ns/1ps
module acp_host_model (
	input  wire logic       go,   // Frame request, rising edge
	input  wire logic       inv,  // Clock idle level
	input  wire logic [4:0] nclk, // Clock periods in the frame
	input  wire logic       sdo,  // Serial data from the converter
	output logic            sclk, // Link clock, 32 ns period
	output logic [15:0]     word, // Bits received, first bit ends on top
	output logic            done  // Frame finished
);
	// Idle state: clock parked, nothing received yet
	initial begin
		sclk = 1'b0;
		word = 16'h0000;
		done = 1'b1;
	end
	// Clock stands still outside frames; leading edge is the update edge
	always @(posedge go) begin
		done = 1'b0;
		sclk = inv;
		#7;
		for (int i = 0; i < nclk; i++) begin
			sclk = ~inv;
			#16;
			// Sample late in the half period, where the data has settled
			word = {word[14:0], sdo};
			sclk = inv;
			#16;
		end
		done = 1'b1;
	end
endmodule : acp_host_model

// [testbench/tb.sv]
/*
 Self-checking bench of the converter control and output port.
 Assumes the design checks its own timing relations with inline assertions.
*/
`timescale 1ns/1ps
module tb;
	localparam int CONV = 10; // Conversion cycles
	localparam int ACQ  = 5;  // Acquisition cycles
	logic        clk, rstn, sclk, ser, ext, sinv, yinv, rdc, lowp, fast; // Stimulus
	logic        pd, rst_in, cs_n, rd_n, cnv_n, go, done;                // Stimulus
	logic [4:0]  nclk;                                                   // Frame length
	logic [15:0] code, dout, oe_n, word;                                 // Data paths
	logic        busy, hold, pwr_red;                                    // Status
	int          bad_count;                                              // Mismatches
	int          checks;                                                 // Comparisons

	acp_top #(.CONV_CYC(CONV), .ACQ_CYC(ACQ), .SCLK_HALF(2)) i_dut (
		.CLK_SYS(clk), .RSTN(rstn), .SCLK_EXT(sclk), .SERIAL_PARALLEL_SELECT(ser),
		.CLOCK_SOURCE_SELECT(ext), .SERIAL_CLOCK_INVERT(sinv), .FRAME_SYNC_INVERT(yinv),
		.READ_MODE_OR_CHAIN_IN(rdc), .LOW_POWER_MODE(lowp), .FAST_RATE_MODE(fast),
		.POWER_DOWN_REQUEST(pd), .RESET_IN(rst_in), .CS_N(cs_n), .RD_N(rd_n),
		.CONVERT_START_N(cnv_n), .SAMPLE_CODE(code), .DATA_OUT(dout), .DATA_OE_N(oe_n),
		.BUSY(busy), .HOLD(hold), .POWER_REDUCED(pwr_red));

	acp_host_model i_host (.go(go), .inv(sinv), .nclk(nclk), .sdo(dout[8]),
		.sclk(sclk), .word(word), .done(done));

	// System clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask : step

	task automatic cmp_bit(input string name, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %b seen %b", name, e, g);
		end
	endtask : cmp_bit

	task automatic cmp_word(input string name, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask : cmp_word

	// Bounded wait for busy; a hang shows up as a mismatch, not a stall
	task automatic wait_busy(input logic v, input int lim);
		int n;
		n = 0;
		while (busy !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		cmp_bit("busy level", v, busy);
	endtask : wait_busy

	// Start pin held low two cycles so the synchroniser sees the edge
	task automatic convert();
		cnv_n <= 1'b0;
		step(2);
		cnv_n <= 1'b1;
	endtask : convert

	// One slave frame of the given length, then wait for its end
	task automatic frame(input logic [4:0] len);
		int n;
		n = 0;
		nclk <= len;
		go   <= 1'b1;
		step(1);
		go <= 1'b0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
	endtask : frame

	task automatic conclude();
		$display("Mismatches %0d, comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// Watchdog: the tests need well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end

	// Main sequence
	initial begin
		int          n;
		int          k;
		logic        p;
		logic        seen;
		logic [15:0] w;
		logic [15:0] e;
		{rstn, ser, ext, sinv, yinv, rdc, lowp, fast, pd, rst_in, go} = 11'h000;
		{cs_n, rd_n, cnv_n} = 3'b111;
		nclk = 5'h00;
		code = 16'hA5C3;
		bad_count = 0;
		checks = 0;
		step(4);
		rstn <= 1'b1;
		step(1);
		cmp_word("oe after reset", 16'hFFFF, oe_n);
		cmp_bit("busy after reset", 1'b0, busy);
		step(3);
		// Parallel conversion: busy span, then a read
		convert();
		wait_busy(1'b1, 8);
		cmp_bit("hold", 1'b1, hold);
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		cmp_word("busy cycles", 16'(CONV + 1), n[15:0]);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		step(5);
		cmp_word("oe parallel", 16'h0000, oe_n);
		cmp_word("data parallel", 16'hA5C3, dout);
		cs_n <= 1'b1;
		step(5);
		cmp_word("oe read only", 16'hFFFF, oe_n);
		rd_n <= 1'b1;
		// Low-power mode: start held low restarts after acquisition
		lowp  <= 1'b1;
		cnv_n <= 1'b0;
		wait_busy(1'b1, 8);
		wait_busy(1'b0, CONV + 4);
		wait_busy(1'b1, ACQ + 4);
		cnv_n <= 1'b1;
		wait_busy(1'b0, CONV + 4);
		lowp <= 1'b0;
		step(ACQ + 3);
		// Reset pin aborts a conversion in progress
		convert();
		wait_busy(1'b1, 8);
		step(3);
		rst_in <= 1'b1;
		wait_busy(1'b0, 5);
		rst_in <= 1'b0;
		step(4);
		// Power-down lets the running conversion finish, then blocks
		convert();
		wait_busy(1'b1, 8);
		pd <= 1'b1;
		wait_busy(1'b0, CONV + 4);
		step(ACQ + 3);
		convert();
		step(8);
		cmp_bit("busy in power-down", 1'b0, busy);
		cmp_bit("power reduced", 1'b1, pwr_red);
		pd <= 1'b0;
		step(3);
		// Master serial read with both clock and sync polarities
		ser <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			e = (m == 0) ? 16'h81E7 : 16'h3C96;
			sinv <= m[0];
			yinv <= m[0];
			code <= e;
			step(2);
			convert();
			wait_busy(1'b1, 8);
			wait_busy(1'b0, CONV + 4);
			cs_n <= 1'b0;
			rd_n <= 1'b0;
			w = 16'h0000;
			k = 0;
			n = 0;
			p = m[0];
			// Capture on the trailing clock edge, where data has been stable
			while (k < 16 && n < 400) begin
				@(posedge clk);
				n++;
				if (p !== m[0] && dout[9] === m[0]) begin
					w = {w[14:0], dout[8]};
					if (k < 15) cmp_bit("frame sync", ~m[0], dout[10]);
					k++;
				end
				p = dout[9];
			end
			cmp_word("oe serial", 16'h00FF, oe_n);
			cmp_word("master word", e, w);
			cs_n <= 1'b1;
			rd_n <= 1'b1;
			step(ACQ + 4);
		end
		// Slave serial read on the link clock, then an overrun
		ext  <= 1'b1;
		sinv <= 1'b0;
		yinv <= 1'b0;
		code <= 16'h6D2B;
		step(3);
		convert();
		wait_busy(1'b1, 8);
		wait_busy(1'b0, CONV + 4);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		step(5);
		// Two leading clocks carry the new-word toggle into the link domain
		frame(5'h12);
		cmp_word("slave word", 16'h6D2B, word);
		// One more clock closes the read so no overrun is left pending
		frame(5'h01);
		code <= 16'h1F80;
		step(ACQ + 2);
		convert();
		wait_busy(1'b1, 8);
		wait_busy(1'b0, CONV + 4);
		step(5);
		frame(5'd8);
		code <= 16'h2468;
		step(ACQ + 2);
		convert();
		seen = 1'b0;
		repeat (CONV + 20) begin
			@(posedge clk);
			if (dout[11] === 1'b1) seen = 1'b1;
		end
		cmp_bit("read error pulse", 1'b1, seen);
		conclude();
	end
endmodule : tb
